/* File: core/bpv_pkg.sv */
package bpv_pkg;

    // ------------------------------------------------------------
    // Register indices (printed offsets are not multiples of four)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_B3_CTL1  = 16'h4060;  // Third converter control one
    localparam logic [15:0] IDX_B3_CTL2  = 16'h4061;  // Third converter control two
    localparam logic [15:0] IDX_B3_ON    = 16'h4062;  // Third converter ON setup
    localparam logic [15:0] IDX_B3_SLP   = 16'h4063;  // buck3_sleep_setup
    localparam logic [15:0] IDX_B4_CTL1  = 16'h4064;  // buck4_control_one
    localparam logic [15:0] IDX_B4_CTL2  = 16'h4065;  // buck4_control_two
    localparam logic [15:0] IDX_B4_ON    = 16'h4066;  // buck4_on_setup
    localparam logic [15:0] IDX_B4_SLP   = 16'h4067;  // buck4_sleep_setup
    localparam logic [15:0] IDX_KEY      = 16'h4070;  // User key register
    localparam logic [15:0] IDX_STATUS   = 16'h4071;  // Effective output status
    localparam int          NUM_REGS     = 8;         // Converter registers in the memory
    localparam logic [15:0] KEY_UNLOCK   = 16'h9716;  // Arbitrary unlock value

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FOLLOW_BIT   = 13;  // Slave-select in control one
    localparam int OVP_BIT      = 7;   // Overvoltage guard in control two
    localparam int LIM_LSB      = 2;   // Hysteretic current cap [3:2]
    localparam int RAMP_LSB     = 4;   // Ramp step length [5:4]
    localparam logic [15:0] CAP_MASK   = 16'h0003;  // Output capacitance, loader only
    localparam logic [15:0] LIM_MASK   = 16'h000c;  // Current cap, key protected
    localparam logic [15:0] CTL1_MASK  = 16'h30bf;  // Writable bits of control one
    localparam logic [15:0] CTL2_MASK  = 16'hdf80;  // Writable bits of control two
    localparam logic [15:0] VSET_MASK  = 16'he37f;  // Writable bits of ON/SLEEP
    localparam logic [15:0] LOAD_ON_MASK = 16'h007c;  // ON code bits held in store

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTL1  = 16'h0014;  // Ramp 01, cap 01
    localparam logic [15:0] RST_CTL2  = 16'h0300;  // Hw-control mode 11, guard off
    localparam logic [15:0] RST_VSET  = 16'h0000;  // Slot, mode and code zero

    // ------------------------------------------------------------
    // Voltage, current and time figures
    // ------------------------------------------------------------
    localparam int  VMIN_MV     = 850;     // Code 00h
    localparam int  VSTEP_UV    = 25000;   // Per code step
    localparam int  VMAX_MV     = 3400;    // Saturation
    localparam logic [6:0] VSAT_CODE = 7'h66;  // First saturated code
    localparam int  CLK_MHZ     = 200;     // Core clock rate
    localparam int  RAMP1_US    = 512;     // Code 01 step length
    localparam int  RAMP2_US    = 4096;    // Code 10 step length
    localparam int  RAMP3_US    = 32768;   // Code 11 step length
    localparam int  RAMP1_CYC   = RAMP1_US * CLK_MHZ;
    localparam int  RAMP2_CYC   = RAMP2_US * CLK_MHZ;
    localparam int  RAMP3_CYC   = RAMP3_US * CLK_MHZ;
    localparam int  LIM_BASE_MA = 50;      // Code 00 cap, doubles per code

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: core/bpv_regmem.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Small register memory with registered read data
// ------------------------------------------------------------
module bpv_regmem
    import bpv_pkg::*;
(
    input  wire logic        aclk,     // Clock
    input  wire logic        aresetn,  // Sync reset, active low
    input  wire logic        we,       // Write strobe
    input  wire logic [2:0]  waddr,    // Write index
    input  wire logic [15:0] wdata,    // Write word
    input  wire logic [2:0]  raddr,    // Read index
    output logic      [15:0] rdata,    // Registered read word
    output logic      [15:0] words [NUM_REGS] // Live contents
);

    logic [15:0] mem       [NUM_REGS];  // Storage
    logic [15:0] next_mem  [NUM_REGS];  // Next storage
    logic [15:0] next_rdata;            // Next read word

    // Reset value of each slot
    function automatic logic [15:0] rst_val(input int i);
        if (i == 0 || i == 4) begin
            return RST_CTL1;
        end else if (i == 1 || i == 5) begin
            return RST_CTL2;
        end else begin
            return RST_VSET;
        end
    endfunction

    // Next contents and read word
    always_comb begin
        next_mem = mem;
        if (we) begin
            next_mem[waddr] = wdata;
        end
        next_rdata = mem[raddr];
    end

    // Storage registers
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (!aresetn) begin
                mem[i] <= rst_val(i);
            end else begin
                mem[i] <= next_mem[i];
            end
        end
        if (!aresetn) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign words = mem;

endmodule

/* File: core/bpv_regs.sv */
// Contract
// - Third ON code: 0.85V plus 25mV, saturating 66h
// - Loader holds only ON code bits 6:2
// - SLEEP code maps exactly like ON code
// - Follow bit: fourth uses third's registers
// - Follow bit written only by loader
// - Ramp field picks step length, four values
// - Current cap 50..400mA, key-protected writes
// - Overvoltage guard bit, resets disabled
`timescale 1ns/1ps

module bpv_regs
    import bpv_pkg::*;
(
    input  wire logic        aclk,          // Clock, 200 MHz
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [17:0] s_axi_awaddr,  // Write byte address, index times four
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [17:0] s_axi_araddr,  // Read byte address, index times four
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        load_valid,    // Loader write strobe
    input  wire logic [2:0]  load_index,    // Loader register index
    input  wire logic [15:0] load_data,     // Loader word
    output logic [11:0]      buck3_out_mv,  // Third converter target, mV
    output logic [11:0]      buck4_out_mv,  // Fourth converter target, mV
    output logic [22:0]      buck3_ramp_cycles, // Third ramp step, cycles
    output logic [22:0]      buck4_ramp_cycles, // Fourth ramp step, cycles
    output logic [8:0]       buck3_cap_ma,  // Third hysteretic cap, mA
    output logic [8:0]       buck4_cap_ma,  // Fourth hysteretic cap, mA
    output logic             buck3_ovp_en,  // Third overvoltage guard
    output logic             buck4_ovp_en,  // Fourth overvoltage guard
    input  wire logic        buck3_sleeping,// Third converter in SLEEP
    input  wire logic        buck4_sleeping // Fourth converter in SLEEP
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    function automatic logic [11:0] code_mv(input logic [6:0] c);
        if (c >= VSAT_CODE) begin
            return 12'(VMAX_MV);
        end
        return 12'(VMIN_MV + (int'(c) * VSTEP_UV) / 1000);
    endfunction

    function automatic logic [22:0] ramp_cyc(input logic [1:0] f);
        case (f)
            2'h0:    return 23'h0;
            2'h1:    return 23'(RAMP1_CYC);
            2'h2:    return 23'(RAMP2_CYC);
            default: return 23'(RAMP3_CYC);
        endcase
    endfunction

    function automatic logic [8:0] cap_ma(input logic [1:0] f);
        return 9'(LIM_BASE_MA << f);
    endfunction

    // Index from byte address; indices reach 4071h, so 17 address bits are needed
    function automatic logic [15:0] word_idx(input logic [17:0] a);
        return a[17:2];
    endfunction

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_RESP} bpv_rd_t;

    logic        aw_held, next_aw_held;     // Address captured
    logic        w_held, next_w_held;       // Data captured
    logic [15:0] aw_idx, next_aw_idx;       // Captured index
    logic [15:0] w_word, next_w_word;       // Captured low half
    logic [1:0]  w_strb, next_w_strb;       // Captured low strobes
    logic        bvalid, next_bvalid;       // Response pending
    logic [1:0]  bresp, next_bresp;         // Response code
    bpv_rd_t     rd_st, next_rd_st;         // Read state
    logic [15:0] ar_idx, next_ar_idx;       // Read index
    logic [31:0] rdata, next_rdata;         // Read word
    logic [1:0]  rresp, next_rresp;         // Read code
    logic [15:0] user_key, next_user_key;   // Key register

    logic [15:0] regs [NUM_REGS];           // Live register words
    logic [15:0] mem_rdata;                 // Registered memory read
    logic        mem_we;                    // Memory write strobe
    logic [2:0]  mem_waddr;                 // Memory write index
    logic [15:0] mem_wdata;                 // Memory write word
    logic        do_write;                  // Host write this cycle
    logic        hit;                       // Converter register hit
    logic [15:0] old_w, new_w, wmask;       // Merge terms
    logic [15:0] lmask;                     // Loader mask

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_arready = (rd_st == RD_IDLE);
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = (rd_st == RD_RESP);
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    // Write channel capture and merge
    always_comb begin
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_idx   = aw_idx;
        next_w_word   = w_word;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_user_key = user_key;
        mem_we    = 1'b0;
        mem_waddr = 3'h0;
        mem_wdata = 16'h0000;
        old_w = 16'h0000;
        new_w = 16'h0000;
        wmask = 16'h0000;
        lmask = 16'h0000;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx  = word_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_word = s_axi_wdata[15:0];
            next_w_strb = s_axi_wstrb[1:0];
        end
        do_write = aw_held && w_held && !bvalid;
        hit = (aw_idx >= IDX_B3_CTL1) && (aw_idx <= IDX_B4_SLP);
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (aw_idx == IDX_KEY) begin
                if (w_strb == 2'h3) begin
                    next_user_key = w_word;
                end
            end else if (hit) begin
                mem_waddr = 3'(aw_idx - IDX_B3_CTL1);
                old_w = regs[mem_waddr];
                if (mem_waddr[1:0] == 2'h0) begin
                    // follow bit and capacitance stay read-only here
                    wmask = CTL1_MASK & ~CAP_MASK & ~(16'h1 << FOLLOW_BIT);
                    if (user_key != KEY_UNLOCK) begin
                        wmask = wmask & ~LIM_MASK;
                    end
                end else if (mem_waddr[1:0] == 2'h1) begin
                    wmask = CTL2_MASK;
                end else begin
                    wmask = VSET_MASK;
                end
                wmask = wmask & {{8{w_strb[1]}}, {8{w_strb[0]}}};
                new_w = (old_w & ~wmask) | (w_word & wmask);
                mem_we = 1'b1;
                mem_wdata = new_w;
            end else if (aw_idx != IDX_STATUS) begin
                next_bresp = RESP_SLVERR;
            end
        end else if (load_valid) begin
            // only ON code bits 6:2 come from the store
            mem_waddr = load_index;
            old_w = regs[load_index];
            if (load_index[1:0] == 2'h0) begin
                // loader may set the follow bit
                lmask = CTL1_MASK | CAP_MASK | (16'h1 << FOLLOW_BIT);
            end else if (load_index[1:0] == 2'h1) begin
                lmask = CTL2_MASK;
            end else if (load_index[1:0] == 2'h2) begin
                lmask = (VSET_MASK & ~16'h007f) | LOAD_ON_MASK;
            end else begin
                lmask = VSET_MASK;
            end
            mem_we = 1'b1;
            mem_wdata = (old_w & ~lmask) | (load_data & lmask);
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // Write state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_idx   <= 16'h0000;
            w_word   <= 16'h0000;
            w_strb   <= 2'h0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
            user_key <= 16'h0000;
        end else begin
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_idx   <= next_aw_idx;
            w_word   <= next_w_word;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            user_key <= next_user_key;
        end
    end

    bpv_regmem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (3'(next_ar_idx - IDX_B3_CTL1)),
        .rdata   (mem_rdata),
        .words   (regs)
    );

    // Read channel: address, memory cycle, answer
    always_comb begin
        next_rd_st  = rd_st;
        next_ar_idx = ar_idx;
        next_rdata  = rdata;
        next_rresp  = rresp;
        case (rd_st)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_ar_idx = word_idx(s_axi_araddr);
                    next_rd_st  = RD_MEM;
                end
            end
            RD_MEM: begin
                next_rd_st = RD_RESP;
                next_rresp = RESP_OKAY;
                if (ar_idx >= IDX_B3_CTL1 && ar_idx <= IDX_B4_SLP) begin
                    next_rdata = {16'h0000, mem_rdata};
                end else if (ar_idx == IDX_KEY) begin
                    next_rdata = {16'h0000, user_key};
                end else if (ar_idx == IDX_STATUS) begin
                    next_rdata = {20'h00000, buck4_out_mv};
                end else begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            end
            default: begin
                if (s_axi_rready) begin
                    next_rd_st = RD_IDLE;
                end
            end
        endcase
    end

    // Read state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st  <= RD_IDLE;
            ar_idx <= 16'h0000;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end else begin
            rd_st  <= next_rd_st;
            ar_idx <= next_ar_idx;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Converter outputs
    // ------------------------------------------------------------
    logic        follow;                // Fourth follows third
    logic [15:0] c1, c2, on4, sl4;      // Fourth's effective sources
    logic [11:0] next_b3_mv, next_b4_mv;
    assign follow = regs[4][FOLLOW_BIT];

    // Decode of both converters
    always_comb begin
        c1  = follow ? regs[0] : regs[4];
        c2  = follow ? regs[1] : regs[5];
        on4 = follow ? regs[2] : regs[6];
        sl4 = follow ? regs[3] : regs[7];
        // ON or SLEEP code by state
        next_b3_mv = code_mv(buck3_sleeping ? regs[3][6:0] : regs[2][6:0]);
        next_b4_mv = code_mv(buck4_sleeping ? sl4[6:0] : on4[6:0]);
    end

    // Output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buck3_out_mv      <= 12'h000;
            buck4_out_mv      <= 12'h000;
            buck3_ramp_cycles <= 23'h0;
            buck4_ramp_cycles <= 23'h0;
            buck3_cap_ma      <= 9'h000;
            buck4_cap_ma      <= 9'h000;
            buck3_ovp_en      <= 1'b0;
            buck4_ovp_en      <= 1'b0;
        end else begin
            buck3_out_mv      <= next_b3_mv;
            buck4_out_mv      <= next_b4_mv;
            buck3_ramp_cycles <= ramp_cyc(regs[0][RAMP_LSB +: 2]);
            buck4_ramp_cycles <= ramp_cyc(c1[RAMP_LSB +: 2]);
            buck3_cap_ma      <= cap_ma(regs[0][LIM_LSB +: 2]);
            buck4_cap_ma      <= cap_ma(c1[LIM_LSB +: 2]);
            buck3_ovp_en      <= regs[1][OVP_BIT];
            buck4_ovp_en      <= c2[OVP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sat;
        @(posedge aclk) disable iff (!aresetn)
        (!buck3_sleeping && regs[2][6:0] >= VSAT_CODE) |=> buck3_out_mv == 12'(VMAX_MV);
    endproperty
    a_sat: assert property (p_sat) else $error("saturated code not clamped");

    property p_follow;
        @(posedge aclk) disable iff (!aresetn)
        follow |=> buck4_ovp_en == $past(regs[1][OVP_BIT]);
    endproperty
    a_follow: assert property (p_follow) else $error("follower ignores third");

    property p_follow_ro;
        @(posedge aclk) disable iff (!aresetn)
        (!load_valid || load_index != 3'h4) |=> follow == $past(follow);
    endproperty
    a_follow_ro: assert property (p_follow_ro) else $error("follow bit changed by host");

    property p_ovp_rst;
        @(posedge aclk) !aresetn |=> !buck3_ovp_en && !buck4_ovp_en;
    endproperty
    a_ovp_rst: assert property (p_ovp_rst) else $error("guard not off after reset");

    property p_load_low;
        @(posedge aclk) disable iff (!aresetn)
        (load_valid && !do_write && load_index == 3'h2)
            |=> regs[2][1:0] == $past(regs[2][1:0]);
    endproperty
    a_load_low: assert property (p_load_low) else $error("loader touched ON low bits");

    property p_cap_lock;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && aw_idx == IDX_B3_CTL1 && user_key != KEY_UNLOCK)
            |=> regs[0][LIM_LSB +: 2] == $past(regs[0][LIM_LSB +: 2]);
    endproperty
    a_cap_lock: assert property (p_cap_lock) else $error("cap written while locked");

endmodule

/* File: bench/bpv_tb.sv */
`timescale 1ns/1ps

module testbench
    import bpv_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals, named as the ports
    // ------------------------------------------------------------
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, load_valid, buck3_ovp_en, buck4_ovp_en;
    logic        buck3_sleeping, buck4_sleeping;
    logic [17:0] s_axi_awaddr, s_axi_araddr; // Byte addresses
    logic [15:0] load_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [2:0]  load_index;
    logic [11:0] buck3_out_mv, buck4_out_mv;
    logic [22:0] buck3_ramp_cycles, buck4_ramp_cycles;
    logic [8:0]  buck3_cap_ma, buck4_cap_ma;
    logic [31:0] rd_word;                   // Last read word
    int          n_errors, samples_checked; // Report counters
    int          ramp_exp [4] = '{0, RAMP1_CYC, RAMP2_CYC, RAMP3_CYC};
    logic [6:0]  codes [5] = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7f}; // Both ends of the clamp

    bpv_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_valid, .load_index,
        .load_data, .buck3_out_mv, .buck4_out_mv, .buck3_ramp_cycles, .buck4_ramp_cycles,
        .buck3_cap_ma, .buck4_cap_ma, .buck3_ovp_en, .buck4_ovp_en, .buck3_sleeping,
        .buck4_sleeping);

    // 200 MHz core clock
    always #2.5 aclk = ~aclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected target in mV; codes from 66h up sit at the ceiling
    function automatic logic [31:0] vexp(input logic [6:0] c);
        return (c >= VSAT_CODE) ? VMAX_MV : VMIN_MV + 25 * c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Write: AW and W offered together, each dropped once taken; bready held until bvalid
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic aw, w;
        int   n;
        aw = 1;
        w = 1;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid && !aw && !w) break;
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (n == 64) n_errors++;
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        repeat (2) @(posedge aclk);
    endtask

    // Read: arvalid held until taken, rready held until rvalid
    task automatic rd(input logic [15:0] idx);
        logic ar;
        int   n;
        ar = 1;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid && !ar) break;
            if (ar && s_axi_arready) begin
                ar = 0;
                s_axi_arvalid <= 1'b0;
            end
        end
        if (n == 64) n_errors++;
        s_axi_rready <= 1'b0;
        rd_word = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
    endtask

    // One loader word, as the configuration store would send it
    task automatic load(input logic [2:0] i, input logic [15:0] d);
        load_valid <= 1'b1;
        load_index <= i;
        load_data <= d;
        @(posedge aclk);
        load_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, load_valid, buck3_sleeping, buck4_sleeping} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, load_data, load_index} = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(buck3_ramp_cycles, RAMP1_CYC);
        chk(buck4_cap_ma, 100);
        chk(buck3_ovp_en, 0);
        // Locked key: the cap field must hold while the ramp field moves
        for (int c = 0; c < 4; c++) begin
            wr(IDX_B3_CTL1, 16'(c << 4) | 16'h000c);
            wr(IDX_B4_CTL1, 16'((3 - c) << 4));
            chk(buck3_ramp_cycles, ramp_exp[c]);
            chk(buck4_ramp_cycles, ramp_exp[3 - c]);
            chk(buck3_cap_ma, 100);
        end
        wr(IDX_KEY, KEY_UNLOCK);
        chk(resp, RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_B3_CTL1, 16'(c << 2));
            wr(IDX_B4_CTL1, 16'((3 - c) << 2));
            chk(buck3_cap_ma, LIM_BASE_MA << c);
            chk(buck4_cap_ma, LIM_BASE_MA << (3 - c));
        end
        wr(IDX_B3_CTL2, 16'h0380);
        wr(IDX_B4_CTL2, 16'h0380);
        chk({buck3_ovp_en, buck4_ovp_en}, 2'b11);
        foreach (codes[i]) begin
            wr(IDX_B3_ON, {9'h000, codes[i]});
            chk(buck3_out_mv, vexp(codes[i]));
        end
        buck3_sleeping <= 1'b1;
        wr(IDX_B3_SLP, 16'h0020);
        chk(buck3_out_mv, vexp(7'h20));
        buck3_sleeping <= 1'b0;
        wr(IDX_B4_ON, 16'h0004);
        chk(buck4_out_mv, vexp(7'h04));
        // Fourth's own SLEEP code while it still runs on its own registers
        buck4_sleeping <= 1'b1;
        wr(IDX_B4_SLP, 16'h0010);
        chk(buck4_out_mv, vexp(7'h10));
        buck4_sleeping <= 1'b0;
        // Loader carries bits 6:2 only; host-written bits 1:0 survive
        wr(IDX_B3_ON, 16'h0003);
        load(3'd2, 16'h0028);
        chk(buck3_out_mv, vexp(7'h2b));
        wr(IDX_B4_CTL1, 16'h2000);
        rd(IDX_B4_CTL1);
        chk(rd_word[13], 1'b0);
        load(3'd4, 16'h2014);
        rd(IDX_B4_CTL1);
        chk(rd_word[13], 1'b1);
        chk(buck4_out_mv, vexp(7'h2b));
        chk(buck4_ramp_cycles, 0);
        // Follower in SLEEP takes the third's SLEEP code, seen through the status word
        buck4_sleeping <= 1'b1;
        rd(IDX_STATUS);
        chk(rd_word, vexp(7'h20));
        rd(16'h4080);
        chk(resp, RESP_SLVERR);
        chk(rd_word, 32'h0);
        close_out();
    end

    // Watchdog, well past the 175 cycles the sequence needs
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule
